// ---- rtl/spi_pin_mode_control.sv ----
// spi pin routing, select pin handling and wait-mode clock stop
//
// What this block does
// - slave ignores fault enable; select is input
// - master, fault disabled: select pin released
// - master, fault enabled: fault input or output
// - both enables set: select driven during transfers
// - single-wire output enable gates data driver
// - single-wire, enable clear: driver off, input only
// - two-wire mode: single-wire enable has no effect
// - halt bit clear: clocks run in wait
// - halt bit set: clocks stop in wait
// - two-wire master: in on miso, out mosi
// - two-wire slave: out on miso, in mosi
// - single-wire master: miso unused, mosi shared
// - single-wire slave: mosi unused, miso shared
// - baud register accessible at any time
`timescale 1ns/1ps
`include "spi_pin_cfg.svh"
module spi_pin_mode_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic [17:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic wait_mode,
  output logic clocks_running,
  input wire logic link_clk,
  input wire logic shift_out,
  input wire logic xfer_active,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_in,
  output logic ss_out,
  output logic ss_oe,
  output logic rx_bit,
  output logic mode_fault_level,
  output logic slave_selected,
  output logic link_running
);

  spi_pin_pkg::bus_state_t b_r;
  spi_pin_pkg::bus_state_t b_nxt;
  spi_pin_pkg::link_state_t l_r;
  spi_pin_pkg::link_state_t l_nxt;
  spi_pin_pkg::cfg_t cfg_bus;
  logic req;
  logic [15:0] idx;
  logic [31:0] rd_mux;
  logic be0;
  logic link_rst;

  // bus request decode
  assign req = read | write;
  assign idx = address[17:2];
  assign be0 = byteenable[0];

  // read mux, unmapped reads return zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      `SPI_IDX_CTRL_ONE: rd_mux[7:0] = b_r.ctrl_one;
      `SPI_IDX_CTRL_TWO: rd_mux[7:0] = b_r.ctrl_two;
      `SPI_IDX_BAUD: rd_mux[7:0] = b_r.baud;
      `SPI_IDX_STATUS:
      begin
        rd_mux[`SPI_ST_RUN] = b_r.run;
        rd_mux[`SPI_ST_SS] = b_r.ss_s[1];
        rd_mux[`SPI_ST_DATA] = b_r.ctrl_one[`SPI_C1_MASTER] ?
          b_r.mosi_s[1] : b_r.miso_s[1];
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus domain next state: slave, pin syncs, clock stop
  always_comb
  begin
    b_nxt = b_r;
    b_nxt.ss_s = {b_r.ss_s[0], ss_in};
    b_nxt.mosi_s = {b_r.mosi_s[0], mosi_in};
    b_nxt.miso_s = {b_r.miso_s[0], miso_in};
    // clocks stop only with halt bit and wait mode
    b_nxt.run = ~(b_r.ctrl_two[`SPI_C2_HALT] & wait_mode);
    if (b_r.wait_r)
    begin
      if (req)
      begin
        b_nxt.wait_r = 1'b0;
        b_nxt.rdata = read ? rd_mux : 32'h0000_0000;
      end
    end
    else
    begin
      b_nxt.wait_r = 1'b1;
      if (write && be0)
      begin
        unique case (idx)
          `SPI_IDX_CTRL_ONE:
            b_nxt.ctrl_one = writedata[7:0] & `SPI_C1_MASK;
          // reserved bits are dropped on write
          `SPI_IDX_CTRL_TWO:
            b_nxt.ctrl_two = writedata[7:0] & `SPI_C2_MASK;
          // no interlock with transfer activity
          `SPI_IDX_BAUD:
            b_nxt.baud = writedata[7:0] & `SPI_BAUD_MASK;
          default: b_nxt.baud = b_r.baud;
        endcase
      end
    end
    if (reset)
    begin
      b_nxt = '0;
      b_nxt.ctrl_one = `SPI_REG_RESET;
      b_nxt.ctrl_two = `SPI_REG_RESET;
      b_nxt.baud = `SPI_REG_RESET;
      b_nxt.wait_r = 1'b1;
      b_nxt.run = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    b_r <= b_nxt;
  end

  // bus domain outputs
  assign readdata = b_r.rdata;
  assign waitrequest = b_r.wait_r;
  assign clocks_running = b_r.run;

  // configuration levels handed to the link domain
  assign cfg_bus.master = b_r.ctrl_one[`SPI_C1_MASTER];
  assign cfg_bus.select_output_enable = b_r.ctrl_one[`SPI_C1_SELECT_OUTPUT_ENABLE];
  assign cfg_bus.fault_detect_enable = b_r.ctrl_two[`SPI_C2_FAULT_DETECT_ENABLE];
  assign cfg_bus.single_wire_output_enable = b_r.ctrl_two[`SPI_C2_SINGLE_WIRE_OUTPUT_ENABLE];
  assign cfg_bus.single = b_r.ctrl_two[`SPI_C2_SPW];
  assign cfg_bus.run = b_r.run;

  assign link_rst = l_r.rst_s[1];

  // link domain: syncs, then pin routing
  always_comb
  begin
    l_nxt = l_r;
    l_nxt.rst_s = {l_r.rst_s[0], reset};
    l_nxt.cfg_s1 = cfg_bus;
    l_nxt.cfg = l_r.cfg_s1;
    l_nxt.pin_s1 = {ss_in, miso_in, mosi_in};
    l_nxt.pin = l_r.pin_s1;
    // a stopped link holds every pin as it was
    if (l_r.cfg.run)
    begin
      l_nxt.mosi_out = shift_out;
      l_nxt.miso_out = shift_out;
      if (l_r.cfg.master)
      begin
        // master: mosi carries data, miso only in two-wire
        if (l_r.cfg.single)
        begin
          l_nxt.mosi_oe = l_r.cfg.single_wire_output_enable;
          l_nxt.miso_oe = 1'b0;
          l_nxt.rx_bit = l_r.pin[0];
        end
        else
        begin
          l_nxt.mosi_oe = 1'b1;
          l_nxt.miso_oe = 1'b0;
          l_nxt.rx_bit = l_r.pin[1];
        end
        l_nxt.selected = 1'b0;
        // select pin by fault enable and output enable
        if (!l_r.cfg.fault_detect_enable)
        begin
          l_nxt.ss_oe = 1'b0;
          l_nxt.ss_out = 1'b0;
          l_nxt.fault = 1'b0;
        end
        else if (l_r.cfg.select_output_enable)
        begin
          l_nxt.ss_oe = 1'b1;
          l_nxt.ss_out = ~xfer_active;
          l_nxt.fault = 1'b0;
        end
        else
        begin
          l_nxt.ss_oe = 1'b0;
          l_nxt.ss_out = 1'b0;
          l_nxt.fault = ~l_r.pin[2];
        end
      end
      else
      begin
        // slave: miso carries data, mosi only in two-wire
        if (l_r.cfg.single)
        begin
          l_nxt.mosi_oe = 1'b0;
          l_nxt.miso_oe = l_r.cfg.single_wire_output_enable;
          l_nxt.rx_bit = l_r.pin[1];
        end
        else
        begin
          l_nxt.mosi_oe = 1'b0;
          l_nxt.miso_oe = 1'b1;
          l_nxt.rx_bit = l_r.pin[0];
        end
        // fault enable ignored, select is always an input
        l_nxt.ss_oe = 1'b0;
        l_nxt.ss_out = 1'b0;
        l_nxt.fault = 1'b0;
        l_nxt.selected = ~l_r.pin[2];
      end
    end
    if (link_rst)
    begin
      l_nxt.cfg = '0;
      l_nxt.cfg_s1 = '0;
      l_nxt.pin = '0;
      l_nxt.pin_s1 = '0;
      l_nxt.mosi_out = 1'b0;
      l_nxt.mosi_oe = 1'b0;
      l_nxt.miso_out = 1'b0;
      l_nxt.miso_oe = 1'b0;
      l_nxt.ss_out = 1'b0;
      l_nxt.ss_oe = 1'b0;
      l_nxt.rx_bit = 1'b0;
      l_nxt.fault = 1'b0;
      l_nxt.selected = 1'b0;
    end
  end

  always_ff @(posedge link_clk)
  begin
    l_r <= l_nxt;
  end

  // link domain outputs, all from flops
  assign mosi_out = l_r.mosi_out;
  assign mosi_oe = l_r.mosi_oe;
  assign miso_out = l_r.miso_out;
  assign miso_oe = l_r.miso_oe;
  assign ss_out = l_r.ss_out;
  assign ss_oe = l_r.ss_oe;
  assign rx_bit = l_r.rx_bit;
  assign mode_fault_level = l_r.fault;
  assign slave_selected = l_r.selected;
  assign link_running = l_r.cfg.run;

  // bus handshake: one wait cycle, then one answer cycle
  sequence s_req_seen;
    req && b_r.wait_r;
  endsequence
  sequence s_answer;
    !b_r.wait_r ##1 b_r.wait_r;
  endsequence

  a_bus_answer: assert property (@(posedge clk) disable iff (reset)
    s_req_seen |=> s_answer)
  else $error("bus answer not after one wait cycle");

  a_baud_write: assert property (@(posedge clk) disable iff (reset)
    write && be0 && !b_r.wait_r && idx == `SPI_IDX_BAUD
    |=> b_r.baud == ($past(writedata[7:0]) & `SPI_BAUD_MASK))
  else $error("baud write not stored");

  a_run_in_wait: assert property (@(posedge clk) disable iff (reset)
    !b_r.ctrl_two[`SPI_C2_HALT] |=> b_r.run)
  else $error("clocks stopped with halt bit clear");

  a_stop_in_wait: assert property (@(posedge clk) disable iff (reset)
    b_r.ctrl_two[`SPI_C2_HALT] && wait_mode |=> !b_r.run)
  else $error("clocks kept running in wait");

  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    b_r.ctrl_two[2] == 1'b0 && b_r.ctrl_two[5] == 1'b0)
  else $error("reserved control bit set");

  a_slave_ss_in: assert property (@(posedge link_clk)
    disable iff (link_rst)
    l_r.cfg.run && !l_r.cfg.master
    |=> !l_r.ss_oe && l_r.selected == !$past(l_r.pin[2]))
  else $error("slave select pin not an input");

  a_master_gpio: assert property (@(posedge link_clk)
    disable iff (link_rst)
    l_r.cfg.run && l_r.cfg.master && !l_r.cfg.fault_detect_enable
    |=> !l_r.ss_oe && !l_r.fault)
  else $error("released select pin still controlled");

  a_fault_input: assert property (@(posedge link_clk)
    disable iff (link_rst)
    l_r.cfg.run && l_r.cfg.master && l_r.cfg.fault_detect_enable && !l_r.cfg.select_output_enable
    |=> !l_r.ss_oe && l_r.fault == !$past(l_r.pin[2]))
  else $error("fault input not following select pin");

  a_ss_auto: assert property (@(posedge link_clk)
    disable iff (link_rst)
    l_r.cfg.run && l_r.cfg.master && l_r.cfg.fault_detect_enable && l_r.cfg.select_output_enable
    |=> l_r.ss_oe && l_r.ss_out == !$past(xfer_active))
  else $error("select output not driven with transfer");

  a_single_master: assert property (@(posedge link_clk)
    disable iff (link_rst)
    l_r.cfg.run && l_r.cfg.single && l_r.cfg.master
    |=> l_r.mosi_oe == $past(l_r.cfg.single_wire_output_enable) && !l_r.miso_oe
    && l_r.rx_bit == $past(l_r.pin[0]))
  else $error("single-wire master routing wrong");

  a_single_input: assert property (@(posedge link_clk)
    disable iff (link_rst)
    l_r.cfg.run && l_r.cfg.single && !l_r.cfg.single_wire_output_enable
    |=> !l_r.mosi_oe && !l_r.miso_oe)
  else $error("driver on with output enable clear");

  a_single_slave: assert property (@(posedge link_clk)
    disable iff (link_rst)
    l_r.cfg.run && l_r.cfg.single && !l_r.cfg.master
    |=> l_r.miso_oe == $past(l_r.cfg.single_wire_output_enable) && !l_r.mosi_oe
    && l_r.rx_bit == $past(l_r.pin[1]))
  else $error("single-wire slave routing wrong");

  a_normal_master: assert property (@(posedge link_clk)
    disable iff (link_rst)
    l_r.cfg.run && !l_r.cfg.single && l_r.cfg.master
    |=> l_r.mosi_oe && !l_r.miso_oe
    && l_r.rx_bit == $past(l_r.pin[1]))
  else $error("two-wire master routing wrong");

  a_normal_slave: assert property (@(posedge link_clk)
    disable iff (link_rst)
    l_r.cfg.run && !l_r.cfg.single && !l_r.cfg.master
    |=> l_r.miso_oe && !l_r.mosi_oe
    && l_r.rx_bit == $past(l_r.pin[0]))
  else $error("two-wire slave routing wrong");

  a_halt_hold: assert property (@(posedge link_clk)
    disable iff (link_rst)
    !l_r.cfg.run |=> $stable(l_r.mosi_oe) && $stable(l_r.miso_oe)
    && $stable(l_r.ss_oe) && $stable(l_r.rx_bit))
  else $error("link pins moved while clocks stopped");

endmodule

// ---- inc/spi_pin_cfg.svh ----
// register indices, field positions and reset values of the pin block
`ifndef SPI_PIN_CFG_SVH
`define SPI_PIN_CFG_SVH
`define SPI_IDX_CTRL_ONE 16'h30a0
`define SPI_IDX_CTRL_TWO 16'h30a1
`define SPI_IDX_BAUD 16'h30a2
`define SPI_IDX_STATUS 16'h30a3
`define SPI_C1_MASTER 0
`define SPI_C1_SELECT_OUTPUT_ENABLE 1
`define SPI_C1_MASK 8'h03
`define SPI_C2_SPW 0
`define SPI_C2_HALT 1
`define SPI_C2_SINGLE_WIRE_OUTPUT_ENABLE 3
`define SPI_C2_FAULT_DETECT_ENABLE 4
`define SPI_C2_MASK 8'hdb
`define SPI_BAUD_MASK 8'h7f
`define SPI_REG_RESET 8'h00
`define SPI_ST_RUN 0
`define SPI_ST_SS 1
`define SPI_ST_DATA 2
`endif

// ---- inc/spi_pin_pkg.sv ----
// types of the pin mode control block
package spi_pin_pkg;
  typedef struct packed {
    logic master;
    logic fault_detect_enable;
    logic select_output_enable;
    logic single_wire_output_enable;
    logic single;
    logic run;
  } cfg_t;
  typedef struct packed {
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] baud;
    logic wait_r;
    logic [31:0] rdata;
    logic run;
    logic [1:0] ss_s;
    logic [1:0] mosi_s;
    logic [1:0] miso_s;
  } bus_state_t;
  typedef struct packed {
    logic [1:0] rst_s;
    cfg_t cfg_s1;
    cfg_t cfg;
    logic [2:0] pin_s1;
    logic [2:0] pin;
    logic mosi_out;
    logic mosi_oe;
    logic miso_out;
    logic miso_oe;
    logic ss_out;
    logic ss_oe;
    logic rx_bit;
    logic fault;
    logic selected;
  } link_state_t;
endpackage

// ---- sim/spi_peer.sv ----
// behavioural spi peer that settles the data and select wire levels
`timescale 1ns/1ps
module spi_peer (
  input wire logic link_clk,
  input wire logic mosi_out,
  input wire logic mosi_oe,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic ss_out,
  input wire logic ss_oe,
  input wire logic data_val,
  input wire logic ss_val,
  output logic mosi_w,
  output logic miso_w,
  output logic ss_w
);
  logic data_q;
  logic ss_q;
  // peer updates its own drive levels just after each link clock edge
  always_ff @(posedge link_clk)
  begin
    data_q <= data_val;
    ss_q <= ss_val;
  end
  // peer drives a data line only while the block leaves it alone
  assign mosi_w = mosi_oe ? mosi_out : data_q;
  assign miso_w = miso_oe ? miso_out : data_q;
  // select line driven by the block when enabled, else by the peer
  assign ss_w = ss_oe ? ss_out : ss_q;
endmodule

// ---- sim/test_spi_pin_mode_control.sv ----
// self-checking bench of the spi pin mode block
`timescale 1ns/1ps
module test_spi_pin_mode_control;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic [17:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = '0;
  logic [3:0] byteenable = 4'hf;
  logic wait_mode = 1'b0;
  logic shift_out = 1'b0;
  logic xfer_active = 1'b0;
  logic data_val = 1'b0;
  logic ss_val = 1'b1;
  logic [31:0] readdata;
  logic waitrequest, clocks_running, mosi_out, mosi_oe, miso_out;
  logic miso_oe, ss_out, ss_oe, rx_bit, mode_fault_level;
  logic slave_selected, link_running, mosi_w, miso_w, ss_w;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] rng = 32'h15;
  logic [31:0] v;
  logic [7:0] rd;
  // bus clock and unrelated link clock
  always #12.5 clk = ~clk;
  always #6 link_clk = ~link_clk;
  spi_pin_mode_control spi_pin_mode_control_i (
    .clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .wait_mode(wait_mode), .clocks_running(clocks_running),
    .link_clk(link_clk), .shift_out(shift_out),
    .xfer_active(xfer_active), .mosi_in(mosi_w), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_in(ss_w), .ss_out(ss_out), .ss_oe(ss_oe),
    .rx_bit(rx_bit), .mode_fault_level(mode_fault_level),
    .slave_selected(slave_selected), .link_running(link_running)
  );
  spi_peer spi_peer_i (
    .link_clk(link_clk), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_out(miso_out), .miso_oe(miso_oe), .ss_out(ss_out),
    .ss_oe(ss_oe), .data_val(data_val), .ss_val(ss_val),
    .mosi_w(mosi_w), .miso_w(miso_w), .ss_w(ss_w)
  );
  // repeatable random source
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // compare of a single pin or flag
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: bit %b, expected %b", $time, got,
        exp);
    end
  endtask
  // compare of a register value
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: reg %h, expected %h", $time, got,
        exp);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [15:0] idx,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    write <= wr;
    read <= ~wr;
    @(posedge clk);
    // only the watchdog ends a wait that never answers
    while (waitrequest !== 1'b0)
    begin
      @(posedge clk);
    end
    q = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask
  // expected pin routing for one configuration
  task automatic check_pins(input logic m, sw, oe, fe, so);
    logic dw;
    dw = m ? mosi_w : miso_w;
    chk_bit(mosi_oe, m & (~sw | oe));
    chk_bit(miso_oe, ~m & (~sw | oe));
    if (m & (~sw | oe)) chk_bit(mosi_w, shift_out);
    if (~m & (~sw | oe)) chk_bit(miso_w, shift_out);
    if (~(sw & oe)) chk_bit(rx_bit, (m ^ sw) ? miso_w : mosi_w);
    if (sw & ~oe) chk_bit(rx_bit, dw);
    chk_bit(ss_oe, m & fe & so);
    if (m & fe & so) chk_bit(ss_out, ~xfer_active);
    if (m & fe & ~so) chk_bit(mode_fault_level, ~ss_w);
    if (~m) chk_bit(slave_selected, ~ss_w);
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial
  begin
    #200000;
    n_errors++;
    complete_run();
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b0, 16'h30a0 + 16'(i), 8'h00, rd);
      chk_reg(rd, 8'h00);
    end
    bus(1'b0, 16'h3000, 8'h00, rd);
    chk_reg(rd, 8'h00);
    // baud round trip while the link is busy or idle
    for (int i = 0; i < 6; i++)
    begin
      v = xs();
      @(posedge link_clk);
      xfer_active <= v[8];
      bus(1'b1, 16'h30a2, v[7:0], rd);
      bus(1'b0, 16'h30a2, 8'h00, rd);
      chk_reg(rd, v[7:0] & 8'h7f);
    end
    // every mix of master, single wire, output and select enables
    for (int i = 0; i < 32; i++)
    begin
      v = xs();
      bus(1'b1, 16'h30a0, {6'h0, i[4], i[0]}, rd);
      bus(1'b1, 16'h30a1, {3'h0, i[3], i[2], 2'h0, i[1]}, rd);
      @(posedge link_clk);
      shift_out <= v[0];
      xfer_active <= v[1];
      data_val <= v[2];
      ss_val <= v[3];
      repeat (10) @(posedge link_clk);
      check_pins(i[0], i[1], i[2], i[3], i[4]);
    end
    // wait mode with halt clear, then set
    bus(1'b1, 16'h30a0, 8'h03, rd);
    bus(1'b1, 16'h30a1, 8'h10, rd);
    wait_mode <= 1'b1;
    repeat (10) @(posedge link_clk);
    chk_bit(clocks_running, 1'b1);
    chk_bit(link_running, 1'b1);
    bus(1'b1, 16'h30a1, 8'h12, rd);
    repeat (10) @(posedge link_clk);
    chk_bit(clocks_running, 1'b0);
    chk_bit(link_running, 1'b0);
    bus(1'b0, 16'h30a3, 8'h00, rd);
    chk_bit(rd[0], 1'b0);
    @(posedge link_clk);
    xfer_active <= ~xfer_active;
    repeat (10) @(posedge link_clk);
    chk_bit(ss_out, xfer_active);
    @(posedge clk);
    wait_mode <= 1'b0;
    repeat (10) @(posedge link_clk);
    chk_bit(clocks_running, 1'b1);
    chk_bit(ss_out, ~xfer_active);
    complete_run();
  end
endmodule
